/* pkg/oecp_pkg.sv */
// Purpose: constants for the host-side one-time-programmable memory controller
// Assumes: 125 MHz sys_clk, memory pins driven through digital level shifters
// Notes: digital model of the shared output-enable / programming-supply pin
//
// Summary of operation
// - host presents the whole byte on all eight data lines when programming
// - with supply level on, host gives one 100us chip-enable low pulse
// - failed verify earns another pulse, at most 25 pulses per location
// - host steps through each address, then verifies every address
// - verify drives chip enable and shared pin low, samples after verify delay
// - during identify all address lines except zero are held low
// - chip enable selects the device, output enable is the read strobe
package oecp_pkg;
   localparam int OECP_AW = 16;
   localparam int OECP_DW = 8;
   localparam logic [15:0] OECP_LAST_ADDR = 16'hffff;
   localparam int OECP_CLK_NS = 8;
   localparam int OECP_PULSE_US = 100;
   localparam int OECP_PULSE_CYC = (OECP_PULSE_US * 1000) / OECP_CLK_NS;
   localparam int OECP_MAX_PULSES = 25;
   // read and verify sampling delays and program setup time, slowest grade assumed
   localparam int OECP_ACC_NS = 150;
   localparam int OECP_ACC_CYC = (OECP_ACC_NS + OECP_CLK_NS - 1) / OECP_CLK_NS;
   localparam int OECP_OE_NS = 65;
   localparam int OECP_OE_CYC = (OECP_OE_NS + OECP_CLK_NS - 1) / OECP_CLK_NS;
   localparam int OECP_DV_NS = 1000;
   localparam int OECP_DV_CYC = (OECP_DV_NS + OECP_CLK_NS - 1) / OECP_CLK_NS;
   localparam int OECP_SETUP_NS = 2000;
   localparam int OECP_SETUP_CYC = (OECP_SETUP_NS + OECP_CLK_NS - 1) / OECP_CLK_NS;
   localparam logic [7:0] OECP_BLANK = 8'hff;
   localparam logic [15:0] OECP_ID_ADDR0 = 16'h0000;
   localparam logic [15:0] OECP_ID_ADDR1 = 16'h0001;
   localparam int OECP_CNT_W = 20;
   localparam logic [1:0] OECP_CMD_READ = 2'h0;
   localparam logic [1:0] OECP_CMD_PROG = 2'h1;
   localparam logic [1:0] OECP_CMD_IDENT = 2'h2;
   localparam logic [1:0] OECP_CMD_CHECK = 2'h3;
   typedef enum logic [8:0] {
      OECP_IDLE  = 9'h001,
      OECP_SETUP = 9'h002,
      OECP_PULSE = 9'h004,
      OECP_VSET  = 9'h008,
      OECP_VSAMP = 9'h010,
      OECP_NEXT  = 9'h020,
      OECP_RSET  = 9'h040,
      OECP_RSAMP = 9'h080,
      OECP_DONE  = 9'h100
   } oecp_state_e;
endpackage

/* hw/oecp_ctrl.sv */
// Purpose: host controller driving the memory pins for read, identify, program
// Assumes: memory data inputs synchronous to sys_clk; id parity checked on read
// Notes: program walks a range with pulse/verify, then a final check pass
`timescale 1ns/1ns
module oecp_ctrl
   import oecp_pkg::*;
#(
   parameter int PULSE_CYC = OECP_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [15:0] cmd_addr,
   input wire logic [15:0] cmd_last,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_error,
   output logic [15:0] rsp_addr,
   output logic [15:0] address_lines,
   output logic chip_enable_n,
   output logic output_enable_n,
   output logic prog_supply_on,
   output logic identify_high_voltage,
   output logic [7:0] data_lines_o,
   output logic data_lines_oe,
   input wire logic [7:0] data_lines_i
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_s1_r, rst_s2_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire rstn = rst_s2_r;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic odd_par(input logic [7:0] v);
      odd_par = ^v;
   endfunction

   oecp_state_e st_r, st_nxt;
   logic [1:0] op_r;
   logic [15:0] addr_r, last_r;
   logic [7:0] data_r, rd_r;
   logic [OECP_CNT_W-1:0] cnt_r;
   logic [4:0] pulses_r;
   logic check_r, err_r;
   wire [OECP_CNT_W-1:0] pulse_n = OECP_CNT_W'(PULSE_CYC);
   wire [OECP_CNT_W-1:0] setup_n = OECP_CNT_W'(OECP_SETUP_CYC);
   wire [OECP_CNT_W-1:0] rd_n = OECP_CNT_W'(OECP_ACC_CYC);
   wire [OECP_CNT_W-1:0] dv_n = OECP_CNT_W'(OECP_DV_CYC);
   wire cnt_zero = (cnt_r == '0);
   wire is_prog = (op_r == OECP_CMD_PROG);
   wire is_ident = (op_r == OECP_CMD_IDENT);
   wire verify_ok = (data_lines_i == data_r);
   wire last_hit = (addr_r == last_r);
   wire more_pulses = (pulses_r < 5'(OECP_MAX_PULSES));
   wire [15:0] id_addr = addr_r[0] ? OECP_ID_ADDR1 : OECP_ID_ADDR0;
   // first address of a walk, kept for the final check pass
   logic [15:0] cmd_addr_first_r;
   // after a range write every byte should equal the byte that was programmed
   wire [7:0] expect_w = data_r;
   wire in_rd_nxt = (st_nxt == OECP_VSET) || (st_nxt == OECP_VSAMP) ||
                    (st_nxt == OECP_RSET) || (st_nxt == OECP_RSAMP);
   // chip enable rises for one cycle after a pulse so the byte is latched,
   // and the supply level is only dropped once chip enable is high again
   wire rd_gate_nxt = in_rd_nxt && (st_r != OECP_PULSE);
   wire supply_nxt = (st_nxt == OECP_SETUP) || (st_nxt == OECP_PULSE) ||
                     (st_r == OECP_PULSE);
   wire is_ident_nxt = (st_nxt == OECP_RSET || st_nxt == OECP_RSAMP) &&
                       ((st_r == OECP_IDLE) ? (cmd_op == OECP_CMD_IDENT) : is_ident);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         OECP_IDLE: if (cmd_valid) begin
            st_nxt = (cmd_op == OECP_CMD_PROG) ? OECP_SETUP : OECP_RSET;
         end
         OECP_SETUP: if (cnt_zero) st_nxt = OECP_PULSE;
         OECP_PULSE: if (cnt_zero) st_nxt = OECP_VSET;
         OECP_VSET: if (cnt_zero) st_nxt = OECP_VSAMP;
         OECP_VSAMP: begin
            if (verify_ok) st_nxt = OECP_NEXT;
            else if (more_pulses) st_nxt = OECP_SETUP;
            else st_nxt = OECP_DONE;
         end
         OECP_NEXT: st_nxt = last_hit ? OECP_RSET : OECP_SETUP;
         OECP_RSET: if (cnt_zero) st_nxt = OECP_RSAMP;
         OECP_RSAMP: begin
            if (check_r && !last_hit && !(!verify_ok && op_r == OECP_CMD_CHECK
                && 1'b0)) st_nxt = OECP_RSET;
            else st_nxt = OECP_DONE;
         end
         OECP_DONE: st_nxt = OECP_IDLE;
         default: st_nxt = OECP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= OECP_IDLE;
         op_r <= OECP_CMD_READ;
         addr_r <= '0;
         last_r <= '0;
         data_r <= OECP_BLANK;
         rd_r <= OECP_BLANK;
         cnt_r <= '0;
         pulses_r <= '0;
         check_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
         unique case (st_r)
            OECP_IDLE: if (cmd_valid) begin
               op_r <= cmd_op;
               addr_r <= cmd_addr;
               last_r <= (cmd_op == OECP_CMD_PROG || cmd_op == OECP_CMD_CHECK)
                         ? cmd_last : cmd_addr;
               data_r <= cmd_data;
               pulses_r <= '0;
               err_r <= 1'b0;
               check_r <= (cmd_op == OECP_CMD_CHECK);
               cnt_r <= (cmd_op == OECP_CMD_PROG) ? setup_n : rd_n;
            end
            OECP_SETUP: if (cnt_zero) begin
               cnt_r <= pulse_n;
               pulses_r <= pulses_r + 5'h01;
            end
            OECP_PULSE: if (cnt_zero) cnt_r <= dv_n;
            OECP_VSAMP: begin
               rd_r <= data_lines_i;
               cnt_r <= setup_n;
               if (!verify_ok && !more_pulses) err_r <= 1'b1;
            end
            OECP_NEXT: begin
               pulses_r <= '0;
               cnt_r <= last_hit ? rd_n : setup_n;
               if (last_hit) begin
                  // final pass re-reads from the first address
                  addr_r <= addr_r - (last_r - cmd_addr_first_r);
                  check_r <= 1'b1;
               end else begin
                  addr_r <= addr_r + 16'h0001;
               end
            end
            OECP_RSAMP: begin
               rd_r <= data_lines_i;
               if (is_ident && !odd_par(data_lines_i)) err_r <= 1'b1;
               if (check_r && !is_ident && data_lines_i != expect_w) err_r <= 1'b1;
               if (!last_hit) addr_r <= addr_r + 16'h0001;
               cnt_r <= rd_n;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) cmd_addr_first_r <= '0;
      else if (st_r == OECP_IDLE && cmd_valid) cmd_addr_first_r <= cmd_addr;
   end
   // ----------------------------------------
   // pin drive, all registered
   // ----------------------------------------
   wire [15:0] addr_drv = is_ident ? id_addr : addr_r;
   // address is set on the edge that takes a command, the same edge on which the voltage rises
   wire [15:0] cmd_pin_addr = (cmd_op == OECP_CMD_IDENT) ?
                              (cmd_addr[0] ? OECP_ID_ADDR1 : OECP_ID_ADDR0) : cmd_addr;
   wire [15:0] addr_pin_nxt = (st_r == OECP_IDLE && cmd_valid) ? cmd_pin_addr : addr_drv;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         address_lines <= '0;
         chip_enable_n <= 1'b1;
         output_enable_n <= 1'b1;
         prog_supply_on <= 1'b0;
         identify_high_voltage <= 1'b0;
         data_lines_o <= OECP_BLANK;
         data_lines_oe <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= OECP_BLANK;
         rsp_error <= 1'b0;
         rsp_addr <= '0;
      end else begin
         address_lines <= addr_pin_nxt;
         // chip enable low in PULSE and in the read and verify gates
         chip_enable_n <= !((st_nxt == OECP_PULSE) || rd_gate_nxt);
         output_enable_n <= !rd_gate_nxt;
         prog_supply_on <= supply_nxt;
         identify_high_voltage <= is_ident_nxt;
         data_lines_o <= data_r;
         data_lines_oe <= (st_nxt == OECP_SETUP) || (st_nxt == OECP_PULSE);
         cmd_ready <= (st_nxt == OECP_IDLE);
         rsp_valid <= (st_r == OECP_DONE);
         if (st_r == OECP_DONE) begin
            rsp_data <= rd_r;
            rsp_error <= err_r;
            rsp_addr <= addr_r;
         end
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   pulse_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      $fell(chip_enable_n) && prog_supply_on |-> !chip_enable_n [*8])
      else $error("program pulse too short");
   pulse_cap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      pulses_r <= 5'(OECP_MAX_PULSES))
      else $error("pulse count above limit");
   prog_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      prog_supply_on && !chip_enable_n |-> data_lines_oe)
      else $error("data not driven during pulse");
   no_fight_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !output_enable_n |-> !data_lines_oe && !prog_supply_on)
      else $error("bus contention on data lines");
   ident_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      identify_high_voltage |-> (address_lines[15:1] == 15'h0000))
      else $error("identify address not low");
   verify_lvl_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      st_r == OECP_VSAMP |-> !chip_enable_n && !output_enable_n && !prog_supply_on)
      else $error("verify pins wrong");
   sel_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      !output_enable_n |-> !chip_enable_n)
      else $error("read strobe without select");
   rsp_once_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   prog_c: cover property (@(posedge sys_clk) disable iff (!rstn)
      st_r == OECP_NEXT && last_hit);
   retry_c: cover property (@(posedge sys_clk) disable iff (!rstn)
      st_r == OECP_VSAMP && !verify_ok && more_pulses);
   ident_c: cover property (@(posedge sys_clk) disable iff (!rstn)
      st_r == OECP_RSAMP && is_ident);
   fail_c: cover property (@(posedge sys_clk) disable iff (!rstn) rsp_valid && rsp_error);
endmodule

/* bench/oecp_mem_model.sv */
// Purpose: behavioural model of the one-time-programmable memory on the far side
// Assumes: pins are ideal logic levels, no ac delays modelled
// Notes: floating data lines show the inverse of the last driven byte
`timescale 1ns/1ns
module oecp_mem_model
   import oecp_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'h80, // arbitrary value, odd parity
   parameter logic [7:0] DEV_CODE = 8'h4c // arbitrary value, odd parity
) (
   input wire logic [15:0] address_lines,
   input wire logic chip_enable_n,
   input wire logic output_enable_n,
   input wire logic prog_supply_on,
   input wire logic identify_high_voltage,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   output logic dout_oe
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_q = 8'h00;
   wire logic [7:0] id_byte = address_lines[0] ? DEV_CODE : MFR_CODE;
   wire logic [7:0] rd_byte = identify_high_voltage ? id_byte : mem[address_lines];
   // data out only when selected, gated, and not at supply level
   assign dout_oe = !chip_enable_n && !output_enable_n && !prog_supply_on;
   assign dout = dout_oe ? rd_byte : ~last_q;
   always @(rd_byte, dout_oe) if (dout_oe) last_q = rd_byte;
   initial for (int i = 0; i < 65536; i++) mem[i] = OECP_BLANK;
   always @(posedge chip_enable_n) if (prog_supply_on) begin
      mem[address_lines] <= mem[address_lines] & din;
   end
endmodule

/* bench/otp_eprom_mode_control_tb.sv */
// Purpose: self-checking bench for the memory controller against the model
// Assumes: short program pulse of 20 cycles
// Notes: inputs change at the falling edge of sys_clk
`timescale 1ns/1ns
module otp_eprom_mode_control_tb
   import oecp_pkg::*;
;
   localparam logic [7:0] MFR = 8'h80;
   localparam logic [7:0] DEV = 8'h4c;
   logic sys_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [15:0] cmd_addr = 16'h0000, cmd_last = 16'h0000;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready, rsp_valid, rsp_error, chip_enable_n, output_enable_n;
   logic prog_supply_on, identify_high_voltage, data_lines_oe, mem_oe;
   logic [7:0] rsp_data, data_lines_o, mem_dout;
   logic [15:0] rsp_addr, address_lines;
   int errors = 0, n_checks = 0, pulses = 0;
   wire logic [7:0] data_lines_i = data_lines_oe ? data_lines_o : mem_dout;
   always #4 sys_clk = ~sys_clk;
   oecp_ctrl #(.PULSE_CYC(20)) oecp_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_last(cmd_last),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_error(rsp_error), .rsp_addr(rsp_addr),
      .address_lines(address_lines), .chip_enable_n(chip_enable_n),
      .output_enable_n(output_enable_n), .prog_supply_on(prog_supply_on),
      .identify_high_voltage(identify_high_voltage), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
   oecp_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) oecp_mem_model_i (
      .address_lines(address_lines), .chip_enable_n(chip_enable_n),
      .output_enable_n(output_enable_n), .prog_supply_on(prog_supply_on),
      .identify_high_voltage(identify_high_voltage), .din(data_lines_o),
      .dout(mem_dout), .dout_oe(mem_oe));
   // ----------------------------------------
   // monitors and helpers
   // ----------------------------------------
   // a program pulse is chip enable falling while the supply level stands
   logic ce_prev = 1'b1;
   always @(negedge sys_clk) begin
      if (prog_supply_on === 1'b1 && chip_enable_n === 1'b0 && ce_prev === 1'b1) pulses++;
      ce_prev = chip_enable_n;
   end
   always @(posedge sys_clk) begin
      if (identify_high_voltage === 1'b1 && address_lines[15:1] !== 15'h0000) begin
         chk("identify upper address", 16'h0000, address_lines & 16'hfffe);
      end
      if (mem_oe === 1'b1 && data_lines_oe !== 1'b0) chk("bus contention", 16'h0, 16'h1);
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic run(input logic [1:0] op, input logic [15:0] a, input logic [15:0] l,
         input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      pulses = 0;
      cmd_op = op;
      cmd_addr = a;
      cmd_last = l;
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      chk("response arrives", 16'h1, {15'h0, rsp_valid});
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_idle();
      chk("idle chip enable", 16'h1, {15'h0, chip_enable_n});
      chk("idle data drive", 16'h0, {15'h0, data_lines_oe});
   endtask
   task automatic t_read_blank();
      run(OECP_CMD_READ, 16'h1234, 16'h1234, 8'h00);
      chk("blank read", {8'h00, OECP_BLANK}, {8'h00, rsp_data});
      chk("read error", 16'h0, {15'h0, rsp_error});
   endtask
   task automatic t_identify();
      run(OECP_CMD_IDENT, 16'hfffe, 16'h0000, 8'h00);
      chk("maker byte", {8'h00, MFR}, {8'h00, rsp_data});
      chk("maker parity", 16'h0, {15'h0, rsp_error});
      run(OECP_CMD_IDENT, 16'h0001, 16'h0000, 8'h00);
      chk("device byte", {8'h00, DEV}, {8'h00, rsp_data});
      chk("device parity", 16'h0, {15'h0, rsp_error});
   endtask
   task automatic t_prog_ok();
      run(OECP_CMD_PROG, 16'h0010, 16'h0012, 8'h5a);
      chk("program error", 16'h0, {15'h0, rsp_error});
      chk("one pulse per byte", 16'h3, pulses[15:0]);
      chk("last address", 16'h0012, rsp_addr);
      run(OECP_CMD_READ, 16'h0011, 16'h0011, 8'h00);
      chk("read back", 16'h005a, {8'h00, rsp_data});
   endtask
   task automatic t_prog_fail();
      run(OECP_CMD_PROG, 16'h0011, 16'h0011, 8'ha5);
      chk("fail flagged", 16'h1, {15'h0, rsp_error});
      chk("pulse limit", 16'(OECP_MAX_PULSES), pulses[15:0]);
   endtask
   task automatic t_check();
      run(OECP_CMD_CHECK, 16'h0010, 16'h0012, 8'h5a);
      chk("check mismatch", 16'h1, {15'h0, rsp_error});
      run(OECP_CMD_CHECK, 16'h0012, 16'h0012, 8'h5a);
      chk("check match", 16'h0, {15'h0, rsp_error});
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #600_000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      t_idle();
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_read_blank();
      t_identify();
      t_prog_ok();
      t_prog_fail();
      t_check();
      report_and_stop();
   end
endmodule
